// File: rtl/ept_pkg.sv
package ept_pkg;
    localparam int EPT_NCH = 8;
    localparam int EPT_CW = 8;
    localparam int EPT_NPAIR = EPT_NCH / 2;

    // Byte addresses on the register bus
    localparam logic [7:0] EPT_OFS_EN = 8'h00;
    localparam logic [7:0] EPT_OFS_POL = 8'h04;
    localparam logic [7:0] EPT_OFS_ALIGN = 8'h08;
    localparam logic [7:0] EPT_OFS_JOIN = 8'h0c;
    localparam logic [7:0] EPT_OFS_PER = 8'h20;
    localparam logic [7:0] EPT_OFS_DUTY = 8'h40;
    localparam logic [7:0] EPT_OFS_CNT = 8'h60;

    // Field positions: per-channel arrays use address bits [4:2] as index
    localparam int EPT_IDX_LSB = 2;
    localparam int EPT_GRP_LSB = 5;

    // Values after reset
    localparam logic [7:0] EPT_RST_EN = 8'h00;
    localparam logic [7:0] EPT_RST_POL = 8'hff;
    localparam logic [7:0] EPT_RST_ALIGN = 8'h00;
    localparam logic [3:0] EPT_RST_JOIN = 4'h0;
    localparam logic [7:0] EPT_RST_PER = 8'hff;
    localparam logic [7:0] EPT_RST_DUTY = 8'h00;

    typedef enum logic {EPT_UP, EPT_DOWN} ept_dir_t;
    typedef enum logic {EPT_IDLE, EPT_ACK} ept_bus_t;
endpackage

// File: rtl/ept_chan.sv
`timescale 1ns/1ns
module ept_chan import ept_pkg::*; #(
    parameter int W = 16
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_en,
    input wire logic i_pol,
    input wire logic i_center,
    input wire logic [W-1:0] i_per,
    input wire logic [W-1:0] i_duty,
    output logic o_out,
    output logic [W-1:0] o_cnt
);
    if (W < 2 || W > 16) begin : g_chk
        $error("ept_chan: W must be 2..16");
    end

    logic [W-1:0] cnt_reg;
    logic [W-1:0] per_sh_reg;
    logic [W-1:0] duty_sh_reg;
    logic center_sh_reg;
    ept_dir_t dir_reg;
    logic out_reg;
    logic boundary;
    logic act;
    logic [W-1:0] thr;

    always_comb begin
        if (per_sh_reg == '0) begin
            boundary = 1'b1;
        end else if (center_sh_reg) begin
            boundary = (dir_reg == EPT_DOWN && cnt_reg == W'(1)) ||
                (dir_reg == EPT_UP && cnt_reg == per_sh_reg &&
                 per_sh_reg == W'(1));
        end else begin
            boundary = (cnt_reg == per_sh_reg - W'(1));
        end
    end

    // Shadows only move at a period edge or while disabled, so a write never cuts a pulse
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            per_sh_reg <= '0;
            duty_sh_reg <= '0;
            center_sh_reg <= 1'b0;
        end else if (!i_en || boundary) begin
            per_sh_reg <= i_per;
            duty_sh_reg <= i_duty;
            center_sh_reg <= i_center;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn || !i_en) begin
            cnt_reg <= '0;
            dir_reg <= EPT_UP;
        end else if (boundary) begin
            cnt_reg <= '0;
            dir_reg <= EPT_UP;
        end else if (center_sh_reg && dir_reg == EPT_UP &&
                     cnt_reg == per_sh_reg) begin
            cnt_reg <= cnt_reg - W'(1);
            dir_reg <= EPT_DOWN;
        end else if (dir_reg == EPT_DOWN) begin
            cnt_reg <= cnt_reg - W'(1);
        end else begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end

    // Centre mode: active for 2*duty counts around the peak
    always_comb begin
        thr = (duty_sh_reg >= per_sh_reg) ? '0 : per_sh_reg - duty_sh_reg;
        if (center_sh_reg) begin
            act = (cnt_reg > thr) || (dir_reg == EPT_UP &&
                cnt_reg >= thr && cnt_reg < per_sh_reg);
        end else begin
            act = cnt_reg < duty_sh_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= (i_en && act) ? i_pol : !i_pol;
        end
    end

    assign o_out = out_reg;
    assign o_cnt = cnt_reg;

    property p_dis_idle;
        @(posedge i_clk) disable iff (!i_rstn)
        !i_en |=> (o_out != $past(i_pol));
    endproperty
    a_dis_idle: assert property (p_dis_idle)
        else $error("disabled channel not at idle level");

    property p_left_wrap;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_en && !center_sh_reg && per_sh_reg != '0 &&
         cnt_reg == per_sh_reg - W'(1)) |=> (cnt_reg == '0);
    endproperty
    a_left_wrap: assert property (p_left_wrap)
        else $error("left-aligned counter did not wrap");

    property p_center_turn;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_en && center_sh_reg && dir_reg == EPT_UP &&
         per_sh_reg > W'(1) && cnt_reg == per_sh_reg) |=>
        (dir_reg == EPT_DOWN && cnt_reg == $past(per_sh_reg) - W'(1));
    endproperty
    a_center_turn: assert property (p_center_turn)
        else $error("centre counter did not turn at the peak");

    property p_zero_duty;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_en && duty_sh_reg == '0) |=> (o_out != $past(i_pol));
    endproperty
    a_zero_duty: assert property (p_zero_duty)
        else $error("zero duty produced an active output");

    property p_full_duty;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_en && per_sh_reg != '0 && duty_sh_reg >= per_sh_reg) |=>
        (o_out == $past(i_pol));
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("full duty produced an inactive output");

    property p_shadow_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_en && !boundary) |=>
        ($stable(per_sh_reg) && $stable(duty_sh_reg));
    endproperty
    a_shadow_hold: assert property (p_shadow_hold)
        else $error("period or duty changed inside a period");

    property p_cnt_bound;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_en && per_sh_reg != '0) |-> (cnt_reg <= per_sh_reg);
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)
        else $error("counter beyond its period");
endmodule

// File: rtl/ept_pwm_timer.sv
`timescale 1ns/1ns
// What this block does
// - Eight PWM channels, each with own 8-bit counter, period and duty.
// - Every enabled channel runs its waveform continuously; a joined pair runs as one.
// - Duty spans never active through always active.
// - Software picks each output's active level.
// - Left-aligned counts up and wraps; centre-aligned counts up then down.
// - Channel pairs 7:6, 5:4, 3:2, 1:0 can join into 16-bit channels.
module ept_pwm_timer import ept_pkg::*; #(
    parameter int CH_W = EPT_CW
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic [EPT_NCH-1:0] o_pwm
);
    if (CH_W != EPT_CW) begin : g_chk
        $error("ept_pwm_timer: CH_W must be 8");
    end

    localparam int JW = 2 * CH_W;

    logic [EPT_NCH-1:0] en_reg;
    logic [EPT_NCH-1:0] pol_reg;
    logic [EPT_NCH-1:0] align_reg;
    logic [EPT_NPAIR-1:0] join_reg;
    logic [CH_W-1:0] per_reg [EPT_NCH];
    logic [CH_W-1:0] duty_reg [EPT_NCH];
    logic [31:0] rdata_reg;
    logic wait_reg;
    ept_bus_t state_reg;

    logic [CH_W-1:0] cnt_byte [EPT_NCH];
    logic [JW-1:0] cnt_w [EPT_NCH];
    logic [EPT_NCH-1:0] pwm_w;
    logic [31:0] rd_mux;
    logic wr;
    logic [2:0] grp;
    logic [2:0] idx;

    assign grp = i_address[7:EPT_GRP_LSB];
    assign idx = i_address[EPT_GRP_LSB-1:EPT_IDX_LSB];
    assign wr = (state_reg == EPT_ACK) && i_write && i_byteenable[0];

    // One wait cycle: request seen, then answer with waitrequest low
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= EPT_IDLE;
            wait_reg <= 1'b1;
        end else begin
            case (state_reg)
                EPT_IDLE: begin
                    if (i_read || i_write) begin
                        state_reg <= EPT_ACK;
                        wait_reg <= 1'b0;
                    end
                end
                EPT_ACK: begin
                    state_reg <= EPT_IDLE;
                    wait_reg <= 1'b1;
                end
                default: begin
                    state_reg <= EPT_IDLE;
                    wait_reg <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (grp == EPT_OFS_PER[7:5]) begin
            rd_mux[CH_W-1:0] = per_reg[idx];
        end else if (grp == EPT_OFS_DUTY[7:5]) begin
            rd_mux[CH_W-1:0] = duty_reg[idx];
        end else if (grp == EPT_OFS_CNT[7:5]) begin
            rd_mux[CH_W-1:0] = cnt_byte[idx];
        end else if (i_address == EPT_OFS_EN) begin
            rd_mux[EPT_NCH-1:0] = en_reg;
        end else if (i_address == EPT_OFS_POL) begin
            rd_mux[EPT_NCH-1:0] = pol_reg;
        end else if (i_address == EPT_OFS_ALIGN) begin
            rd_mux[EPT_NCH-1:0] = align_reg;
        end else if (i_address == EPT_OFS_JOIN) begin
            rd_mux[EPT_NPAIR-1:0] = join_reg;
        end
    end

    // Read data is caught on the request edge and held through the answer
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (state_reg == EPT_IDLE && i_read) begin
            rdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            en_reg <= EPT_RST_EN;
            pol_reg <= EPT_RST_POL;
            align_reg <= EPT_RST_ALIGN;
            join_reg <= EPT_RST_JOIN;
        end else if (wr) begin
            if (i_address == EPT_OFS_EN) begin
                en_reg <= i_writedata[EPT_NCH-1:0];
            end
            if (i_address == EPT_OFS_POL) begin
                pol_reg <= i_writedata[EPT_NCH-1:0];
            end
            if (i_address == EPT_OFS_ALIGN) begin
                align_reg <= i_writedata[EPT_NCH-1:0];
            end
            if (i_address == EPT_OFS_JOIN) begin
                join_reg <= i_writedata[EPT_NPAIR-1:0];
            end
        end
    end

    genvar i;
    for (i = 0; i < EPT_NCH; i++) begin : g_ch
        logic [JW-1:0] per_in;
        logic [JW-1:0] duty_in;
        logic ch_en;

        always_ff @(posedge i_clk) begin
            if (!i_rstn) begin
                per_reg[i] <= EPT_RST_PER;
                duty_reg[i] <= EPT_RST_DUTY;
            end else if (wr && idx == 3'(i)) begin
                if (grp == EPT_OFS_PER[7:5]) begin
                    per_reg[i] <= i_writedata[CH_W-1:0];
                end
                if (grp == EPT_OFS_DUTY[7:5]) begin
                    duty_reg[i] <= i_writedata[CH_W-1:0];
                end
            end
        end

        if (i % 2 == 1) begin : g_odd
            // Odd channel holds the high byte and drives the joined pin
            always_comb begin
                if (join_reg[i/2]) begin
                    per_in = {per_reg[i], per_reg[i-1]};
                    duty_in = {duty_reg[i], duty_reg[i-1]};
                end else begin
                    per_in = {{CH_W{1'b0}}, per_reg[i]};
                    duty_in = {{CH_W{1'b0}}, duty_reg[i]};
                end
            end
            assign ch_en = en_reg[i];
            assign cnt_byte[i] = join_reg[i/2] ?
                cnt_w[i][JW-1:CH_W] : cnt_w[i][CH_W-1:0];
        end else begin : g_even
            assign per_in = {{CH_W{1'b0}}, per_reg[i]};
            assign duty_in = {{CH_W{1'b0}}, duty_reg[i]};
            // A joined even pin idles at its inactive level
            assign ch_en = en_reg[i] && !join_reg[i/2];
            assign cnt_byte[i] = join_reg[i/2] ?
                cnt_w[i+1][CH_W-1:0] : cnt_w[i][CH_W-1:0];
        end

        ept_chan #(
            .W(JW)
        ) u_chan (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_en(ch_en),
            .i_pol(pol_reg[i]),
            .i_center(align_reg[i]),
            .i_per(per_in),
            .i_duty(duty_in),
            .o_out(pwm_w[i]),
            .o_cnt(cnt_w[i])
        );
    end

    for (i = 0; i < EPT_NPAIR; i++) begin : g_pair
        property p_join_even;
            @(posedge i_clk) disable iff (!i_rstn)
            join_reg[i] |=> (o_pwm[2*i] != $past(pol_reg[2*i]));
        endproperty
        a_join_even: assert property (p_join_even)
            else $error("joined even pin is not idle");
    end

    assign o_pwm = pwm_w;
    assign o_readdata = rdata_reg;
    assign o_waitrequest = wait_reg;

    property p_wait_pulse;
        @(posedge i_clk) disable iff (!i_rstn)
        !o_waitrequest |=> o_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("waitrequest low for more than one cycle");

    property p_answer;
        @(posedge i_clk) disable iff (!i_rstn)
        ((i_read || i_write) && state_reg == EPT_IDLE) |=>
        !o_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered on the next cycle");

    property p_en_write;
        @(posedge i_clk) disable iff (!i_rstn)
        (wr && i_address == EPT_OFS_EN) |=>
        (en_reg == $past(i_writedata[EPT_NCH-1:0]));
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable register did not take written value");

    property p_per_write;
        @(posedge i_clk) disable iff (!i_rstn)
        (wr && grp == EPT_OFS_PER[7:5] && idx == 3'd0) |=>
        (per_reg[0] == $past(i_writedata[CH_W-1:0]));
    endproperty
    a_per_write: assert property (p_per_write)
        else $error("period register did not take written value");
endmodule

// File: dv/test_ept_pwm_timer.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module test_ept_pwm_timer import ept_pkg::*;;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_address = 8'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'h0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic [EPT_NCH-1:0] o_pwm;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] q;
    logic [7:0] pol = 8'hff;
    int per[8];
    int duty[8];
    int act[8];
    int runs[$];
    int ex;
    logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h40, 8'h10};
    logic [31:0] rv[7] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'hff, 32'h0, 32'h0};

    ept_pwm_timer dut_u (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .o_pwm(o_pwm)
    );

    always #20 i_clk = ~i_clk;

    task automatic summarize();
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Request held to the rising edge that sees waitrequest low; the
    // watchdog alone ends a wait that never completes
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= be;
        i_write <= wr;
        i_read <= !wr;
        @(negedge i_clk);
        while (o_waitrequest !== 1'b0) begin
            @(negedge i_clk);
        end
        @(posedge i_clk);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        `CHK("readdata", e, q)
    endtask

    // Counts active cycles per channel and pulse lengths on channel 2
    task automatic measure(input int w, input logic [7:0] en);
        int rl;
        rl = 0;
        runs.delete();
        act = '{default: 0};
        repeat (w) begin
            @(negedge i_clk);
            for (int k = 0; k < 8; k++) begin
                if (en[k]) act[k] += int'(o_pwm[k] === pol[k]);
                else `CHK("idle_level", !pol[k], o_pwm[k])
            end
            if (o_pwm[2] === pol[2]) begin
                rl++;
            end else if (rl > 0) begin
                runs.push_back(rl);
                rl = 0;
            end
        end
        // Hand back on a rising edge so the next request starts there
        @(posedge i_clk);
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        summarize();
    end

    initial begin
        void'($urandom(32'hef62397d));
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(negedge i_clk);
        `CHK("pwm_after_reset", 8'h00, o_pwm)
        `CHK("wait_after_reset", 1'b1, o_waitrequest)
        @(posedge i_clk);
        for (int i = 0; i < 7; i++) rdc(ra[i], rv[i]);
        wr(8'h10, 32'h5a);
        rdc(8'h10, 32'h0);
        bus(1'b1, EPT_OFS_PER, 32'h12, 4'h0);
        rdc(EPT_OFS_PER, 32'hff);
        // Both alignments; whole-period windows make the phase irrelevant
        for (int m = 0; m < 2; m++) begin
            wr(EPT_OFS_EN, 32'h0);
            wr(EPT_OFS_ALIGN, m ? 32'hff : 32'h0);
            pol = 8'($urandom);
            wr(EPT_OFS_POL, {24'h0, pol});
            for (int k = 0; k < 8; k++) begin
                per[k] = 2 << ($urandom % 4);
                duty[k] = (k == 0) ? 0 : (k == 1) ? per[k] :
                    1 + int'($urandom % (per[k] - 1));
                wr(EPT_OFS_PER + 8'(4 * k), 32'(per[k]));
                wr(EPT_OFS_DUTY + 8'(4 * k), 32'(duty[k]));
                rdc(EPT_OFS_PER + 8'(4 * k), 32'(per[k]));
            end
            wr(EPT_OFS_EN, 32'hff);
            repeat (40) @(posedge i_clk);
            measure(160, 8'hff);
            for (int k = 0; k < 8; k++) begin
                ex = 160 / per[k] * duty[k];
                `CHK("active_cycles", ex, act[k])
            end
            ex = m ? 2 * duty[2] : duty[2];
            for (int i = 1; i < runs.size(); i++)
                `CHK("pulse_len", ex, runs[i])
            bus(1'b0, EPT_OFS_CNT + 8'd12, 32'h0, 4'hf);
            `CHK("count_range", 1'b1, q <= 32'(per[3]))
        end
        wr(EPT_OFS_EN, 32'h0);
        wr(EPT_OFS_ALIGN, 32'h0);
        wr(EPT_OFS_JOIN, 32'h1);
        rdc(EPT_OFS_JOIN, 32'h1);
        wr(EPT_OFS_PER + 8'd4, 32'h01);
        wr(EPT_OFS_PER, 32'h2c);
        wr(EPT_OFS_DUTY + 8'd4, 32'h0);
        wr(EPT_OFS_DUTY, 32'h64);
        wr(EPT_OFS_EN, 32'h03);
        repeat (20) @(posedge i_clk);
        measure(600, 8'h02);
        `CHK("joined_active", 200, act[1])
        // Duty change mid-period must never cut a pulse short
        wr(EPT_OFS_EN, 32'h0);
        wr(EPT_OFS_JOIN, 32'h0);
        wr(EPT_OFS_PER + 8'd8, 32'h8);
        wr(EPT_OFS_DUTY + 8'd8, 32'h2);
        wr(EPT_OFS_EN, 32'h04);
        repeat (20) @(posedge i_clk);
        fork
            measure(160, 8'h04);
            begin
                repeat (37) @(posedge i_clk);
                wr(EPT_OFS_DUTY + 8'd8, 32'h6);
            end
        join
        for (int i = 1; i < runs.size(); i++)
            `CHK("no_glitch", 1'b1, runs[i] == 2 || runs[i] == 6)
        `CHK("new_duty", 6, runs[runs.size() - 1])
        summarize();
    end
endmodule
